// ==== hw/ddrs_consts.vh ====
// constants for the burst-of-two common-i/o sram core
// assumes plain verilog-2005 consumers that include it by bare name
`ifndef DDRS_CONSTS_VH
`define DDRS_CONSTS_VH
// bus geometry
`define DDRS_AW 20
`define DDRS_MAW 21
`define DDRS_DW 18
`define DDRS_NB 2
`define DDRS_BYTE 9
// synchroniser bundle width
`define DDRS_SYNC_W 48
// output event fifo
`define DDRS_EV_W 21
`define DDRS_FIFO_DEPTH 16
`define DDRS_FIFO_AW 4
// impedance calibration
`define DDRS_IW 6
`define DDRS_IMP_MID 6'h20
`define DDRS_IMP_MAX 6'h3f
`define DDRS_IMP_MIN 6'h00
`define DDRS_IMP_CNT_W 11
`define DDRS_IMP_INIT_CYC 11'h400
`define DDRS_IMP_RECAL_CYC 11'h400
`endif

// ==== hw/ddrs_sram.v ====
// burst-of-two double-data-rate common-i/o sram core and its output fifo
// assumes all pins arrive asynchronous to clock; link clocks are sampled
`timescale 1ns/1ps
`include "ddrs_consts.vh"

// ----------------------------------------
// output event fifo
// ----------------------------------------
module ddrs_fifo #(
    parameter W = `DDRS_EV_W,
    parameter DEPTH = `DDRS_FIFO_DEPTH,
    parameter AW = `DDRS_FIFO_AW
) (
    input wire clock,
    input wire nrst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
reg [W-1:0] mem [0:DEPTH-1];
reg [AW:0] wp_r;
reg [AW:0] rp_r;
wire full;
wire empty;
assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
assign empty = (wp_r == rp_r);
assign in_ready = ~full;
assign out_valid = ~empty;
assign out_data = mem[rp_r[AW-1:0]];
always @(posedge clock)
begin
    if (in_valid && !full)
        mem[wp_r[AW-1:0]] <= in_data;
end
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        wp_r <= {(AW+1){1'b0}};
        rp_r <= {(AW+1){1'b0}};
    end
    else
    begin
        if (in_valid && !full)
            wp_r <= wp_r + 1'b1;
        if (out_ready && !empty)
            rp_r <= rp_r + 1'b1;
    end
end
endmodule

// What this block does
// - write only bytes whose mask is low
// - masks sampled with their own data beat
// - every access moves exactly two words
// - read starts on high read_not_write at K
// - first read word at K-bar, 2.5 cycles
// - second read word at K, 3 cycles
// - free-running echo clocks aligned with data
// - new address taken when load low at K
// - load high is nop, drivers self-release
// - write starts on low read_not_write, address taken
// - write word0 at next K, word1 at K-bar
// - writes buffered, committed on third write
// - reads see buffered and newest write data
// - masks per burst address independently
// - read cycle leaves array untouched
// - drive impedance tracks one fifth of resistor
// - reference at supply selects minimum impedance
// - impedance starts mid, settles within 1024 cycles
// - impedance recalibrated periodically
// - termination tracks resistor, range by control pin
// - load low: read_not_write picks access type
// - valid flag pulses half cycle, falls as first word starts
// - dll bypassed gives one-cycle read latency
module ddrs_sram (
    input wire clock,
    input wire nrst,
    input wire k_clk,
    input wire k_clk_n,
    input wire load_address_n,
    input wire read_not_write,
    input wire [`DDRS_AW-1:0] sync_address_in,
    input wire [`DDRS_DW-1:0] dq_in,
    input wire [`DDRS_NB-1:0] byte_write_mask_n,
    input wire dll_bypass_n,
    input wire termination_control,
    input wire impedance_ref_pin_at_supply,
    input wire impedance_ref_pin_cmp_high,
    output reg [`DDRS_DW-1:0] dq_out_r,
    output reg dq_oe_r,
    output reg echo_clock_true_r,
    output reg echo_clock_comp_r,
    output reg output_valid_flag_r,
    output reg [`DDRS_IW-1:0] drive_imp_code_r,
    output reg [`DDRS_IW-1:0] term_imp_code_r,
    output reg term_enable_r
);
localparam W_IDLE = 3'h1;
localparam W_BEAT0 = 3'h2;
localparam W_BEAT1 = 3'h4;

// ----------------------------------------
// synchronisers and edge finders
// ----------------------------------------
reg [`DDRS_SYNC_W-1:0] s1_r;
reg [`DDRS_SYNC_W-1:0] s2_r;
reg k_s3_r;
reg kn_s3_r;
// edges are ignored until the synchroniser and the third flop hold real samples
reg [2:0] sync_fill_r;
wire [`DDRS_SYNC_W-1:0] in_bus;
assign in_bus = {k_clk, k_clk_n, load_address_n, read_not_write, dll_bypass_n,
    termination_control, impedance_ref_pin_at_supply, impedance_ref_pin_cmp_high,
    byte_write_mask_n, sync_address_in, dq_in};
wire k_s = s2_r[47];
wire kn_s = s2_r[46];
wire load_n = s2_r[45];
wire rnw = s2_r[44];
wire dll_on = s2_r[43];
wire term_sel = s2_r[42];
wire ref_at_supply = s2_r[41];
wire ref_cmp_high = s2_r[40];
wire [`DDRS_NB-1:0] mask_n = s2_r[39:38];
wire [`DDRS_AW-1:0] addr = s2_r[37:18];
wire [`DDRS_DW-1:0] din = s2_r[17:0];
wire k_rise = k_s & ~k_s3_r & sync_fill_r[2];
wire kn_rise = kn_s & ~kn_s3_r & sync_fill_r[2];
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        s1_r <= {`DDRS_SYNC_W{1'b0}};
        s2_r <= {`DDRS_SYNC_W{1'b0}};
        k_s3_r <= 1'b0;
        kn_s3_r <= 1'b0;
        sync_fill_r <= 3'h0;
    end
    else
    begin
        s1_r <= in_bus;
        s2_r <= s1_r;
        k_s3_r <= k_s;
        kn_s3_r <= kn_s;
        sync_fill_r <= {sync_fill_r[1:0], 1'b1};
    end
end

// ----------------------------------------
// storage array and write buffers
// ----------------------------------------
reg [`DDRS_DW-1:0] mem [0:(1<<`DDRS_MAW)-1];
reg [2:0] wst_r;
reg [`DDRS_AW-1:0] cur_a_r;
reg [`DDRS_DW-1:0] cur_d0_r;
reg [`DDRS_NB-1:0] cur_m0_r;
reg cur_have0_r;
reg wb0_v_r;
reg [`DDRS_AW-1:0] wb0_a_r;
reg [`DDRS_DW-1:0] wb0_d0_r;
reg [`DDRS_DW-1:0] wb0_d1_r;
reg [`DDRS_NB-1:0] wb0_m0_r;
reg [`DDRS_NB-1:0] wb0_m1_r;
reg wb1_v_r;
reg [`DDRS_AW-1:0] wb1_a_r;
reg [`DDRS_DW-1:0] wb1_d0_r;
reg [`DDRS_DW-1:0] wb1_d1_r;
reg [`DDRS_NB-1:0] wb1_m0_r;
reg [`DDRS_NB-1:0] wb1_m1_r;
wire burst_done = kn_rise && (wst_r == W_BEAT1);
wire evict = burst_done && wb1_v_r;

// overlay the bytes whose mask is low
function [`DDRS_DW-1:0] merge;
    input [`DDRS_DW-1:0] base;
    input [`DDRS_DW-1:0] d;
    input [`DDRS_NB-1:0] m;
    integer i;
    begin
        merge = base;
        for (i = 0; i < `DDRS_NB; i = i + 1)
            if (!m[i])
                merge[i*`DDRS_BYTE +: `DDRS_BYTE] = d[i*`DDRS_BYTE +: `DDRS_BYTE];
    end
endfunction

// array value with older, then newer, buffered writes laid over it
function [`DDRS_DW-1:0] lookup;
    input [`DDRS_AW-1:0] a;
    input w;
    begin
        lookup = mem[{a, w}];
        if (wb1_v_r && wb1_a_r == a)
            lookup = merge(lookup, w ? wb1_d1_r : wb1_d0_r, w ? wb1_m1_r : wb1_m0_r);
        if (wb0_v_r && wb0_a_r == a)
            lookup = merge(lookup, w ? wb0_d1_r : wb0_d0_r, w ? wb0_m1_r : wb0_m0_r);
        if (cur_have0_r && !w && cur_a_r == a)
            lookup = merge(lookup, cur_d0_r, cur_m0_r);
    end
endfunction

// oldest buffered burst goes to the array when a third write completes
always @(posedge clock)
begin
    if (evict)
    begin
        mem[{wb1_a_r, 1'b0}] <= merge(mem[{wb1_a_r, 1'b0}], wb1_d0_r, wb1_m0_r);
        mem[{wb1_a_r, 1'b1}] <= merge(mem[{wb1_a_r, 1'b1}], wb1_d1_r, wb1_m1_r);
    end
end

always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        wst_r <= W_IDLE;
        cur_a_r <= {`DDRS_AW{1'b0}};
        cur_d0_r <= {`DDRS_DW{1'b0}};
        cur_m0_r <= {`DDRS_NB{1'b1}};
        cur_have0_r <= 1'b0;
        wb0_v_r <= 1'b0;
        wb0_a_r <= {`DDRS_AW{1'b0}};
        wb0_d0_r <= {`DDRS_DW{1'b0}};
        wb0_d1_r <= {`DDRS_DW{1'b0}};
        wb0_m0_r <= {`DDRS_NB{1'b1}};
        wb0_m1_r <= {`DDRS_NB{1'b1}};
        wb1_v_r <= 1'b0;
        wb1_a_r <= {`DDRS_AW{1'b0}};
        wb1_d0_r <= {`DDRS_DW{1'b0}};
        wb1_d1_r <= {`DDRS_DW{1'b0}};
        wb1_m0_r <= {`DDRS_NB{1'b1}};
        wb1_m1_r <= {`DDRS_NB{1'b1}};
    end
    else
    begin
        case (wst_r)
            W_IDLE:
            begin
                if (k_rise && !load_n && !rnw)
                begin
                    cur_a_r <= addr;
                    wst_r <= W_BEAT0;
                end
            end
            W_BEAT0:
            begin
                if (k_rise)
                begin
                    cur_d0_r <= din;
                    cur_m0_r <= mask_n;
                    cur_have0_r <= 1'b1;
                    wst_r <= W_BEAT1;
                end
            end
            W_BEAT1:
            begin
                if (kn_rise)
                begin
                    wb1_v_r <= wb0_v_r;
                    wb1_a_r <= wb0_a_r;
                    wb1_d0_r <= wb0_d0_r;
                    wb1_d1_r <= wb0_d1_r;
                    wb1_m0_r <= wb0_m0_r;
                    wb1_m1_r <= wb0_m1_r;
                    wb0_v_r <= 1'b1;
                    wb0_a_r <= cur_a_r;
                    wb0_d0_r <= cur_d0_r;
                    wb0_d1_r <= din;
                    wb0_m0_r <= cur_m0_r;
                    wb0_m1_r <= mask_n;
                    cur_have0_r <= 1'b0;
                    wst_r <= W_IDLE;
                end
            end
            default:
            begin
                wst_r <= W_IDLE;
            end
        endcase
    end
end

// ----------------------------------------
// read pipeline and output events
// ----------------------------------------
reg [2:0] rd_pipe_r;
reg [`DDRS_AW-1:0] ra0_r;
reg [`DDRS_AW-1:0] ra1_r;
reg [`DDRS_AW-1:0] ra2_r;
reg [`DDRS_DW-1:0] core_q_r;
reg core_oe_r;
reg core_qv_r;
reg core_echo_r;
reg ev_v_r;
wire rd_cmd = !load_n && rnw;
wire fifo_in_ready;
wire fifo_out_valid;
wire [`DDRS_EV_W-1:0] fifo_out_data;
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        rd_pipe_r <= 3'h0;
        ra0_r <= {`DDRS_AW{1'b0}};
        ra1_r <= {`DDRS_AW{1'b0}};
        ra2_r <= {`DDRS_AW{1'b0}};
        core_q_r <= {`DDRS_DW{1'b0}};
        core_oe_r <= 1'b0;
        core_qv_r <= 1'b0;
        core_echo_r <= 1'b0;
        ev_v_r <= 1'b0;
    end
    else
    begin
        // every k edge leaves one event; it waits while the fifo is full
        ev_v_r <= k_rise | kn_rise | (ev_v_r & ~fifo_in_ready);
        if (k_rise)
        begin
            rd_pipe_r <= {rd_pipe_r[1:0], rd_cmd};
            ra0_r <= addr;
            ra1_r <= ra0_r;
            ra2_r <= ra1_r;
            core_echo_r <= 1'b1;
            if (dll_on)
            begin
                core_qv_r <= rd_pipe_r[1];
                if (rd_pipe_r[2])
                begin
                    core_q_r <= lookup(ra2_r, 1'b1);
                    core_oe_r <= 1'b1;
                end
            end
            else
            begin
                core_qv_r <= 1'b0;
                core_oe_r <= rd_pipe_r[0];
                if (rd_pipe_r[0])
                    core_q_r <= lookup(ra0_r, 1'b0);
            end
        end
        else if (kn_rise)
        begin
            core_echo_r <= 1'b0;
            if (dll_on)
            begin
                core_qv_r <= 1'b0;
                core_oe_r <= rd_pipe_r[2];
                if (rd_pipe_r[2])
                    core_q_r <= lookup(ra2_r, 1'b0);
            end
            else
            begin
                core_qv_r <= rd_pipe_r[0];
                core_oe_r <= rd_pipe_r[1];
                if (rd_pipe_r[1])
                    core_q_r <= lookup(ra1_r, 1'b1);
            end
        end
    end
end

ddrs_fifo #(
    .W(`DDRS_EV_W),
    .DEPTH(`DDRS_FIFO_DEPTH),
    .AW(`DDRS_FIFO_AW)
) u_ev_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(ev_v_r),
    .in_ready(fifo_in_ready),
    .in_data({core_echo_r, core_qv_r, core_oe_r, core_q_r}),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
);

// ----------------------------------------
// pin stage: echo clocks, flag and data move together
// ----------------------------------------
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        dq_out_r <= {`DDRS_DW{1'b0}};
        dq_oe_r <= 1'b0;
        echo_clock_true_r <= 1'b0;
        echo_clock_comp_r <= 1'b1;
        output_valid_flag_r <= 1'b0;
        term_enable_r <= 1'b1;
    end
    else if (fifo_out_valid)
    begin
        echo_clock_true_r <= fifo_out_data[20];
        echo_clock_comp_r <= ~fifo_out_data[20];
        output_valid_flag_r <= fifo_out_data[19];
        dq_oe_r <= fifo_out_data[18];
        dq_out_r <= fifo_out_data[17:0];
        term_enable_r <= ~fifo_out_data[18];
    end
end

// ----------------------------------------
// impedance calibration
// ----------------------------------------
reg [`DDRS_IMP_CNT_W-1:0] imp_cnt_r;
reg imp_init_done_r;
wire imp_step = !imp_init_done_r || (imp_cnt_r == `DDRS_IMP_RECAL_CYC - 1'b1);
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        imp_cnt_r <= {`DDRS_IMP_CNT_W{1'b0}};
        imp_init_done_r <= 1'b0;
        drive_imp_code_r <= `DDRS_IMP_MID;
        term_imp_code_r <= `DDRS_IMP_MID;
    end
    else
    begin
        if (!imp_init_done_r && imp_cnt_r == `DDRS_IMP_INIT_CYC - 1'b1)
        begin
            imp_init_done_r <= 1'b1;
            imp_cnt_r <= {`DDRS_IMP_CNT_W{1'b0}};
        end
        else if (imp_init_done_r && imp_step)
            imp_cnt_r <= {`DDRS_IMP_CNT_W{1'b0}};
        else
            imp_cnt_r <= imp_cnt_r + 1'b1;
        if (imp_step)
        begin
            if (ref_at_supply)
                drive_imp_code_r <= `DDRS_IMP_MAX;
            else if (ref_cmp_high && drive_imp_code_r != `DDRS_IMP_MAX)
                drive_imp_code_r <= drive_imp_code_r + 1'b1;
            else if (!ref_cmp_high && drive_imp_code_r != `DDRS_IMP_MIN)
                drive_imp_code_r <= drive_imp_code_r - 1'b1;
        end
        // high control keeps the full code, low halves it
        term_imp_code_r <= term_sel ? drive_imp_code_r : {1'b0, drive_imp_code_r[`DDRS_IW-1:1]};
    end
end
endmodule

// ==== verification/ddrs_monitor.sv ====
// assertions on the output pins of the burst-of-two sram core
// assumes it is bound into ddrs_sram and that every check runs on clock
`timescale 1ns/1ps
`include "ddrs_consts.vh"
module ddrs_monitor (
    input logic clock,
    input logic nrst,
    input logic [`DDRS_DW-1:0] dq_out_r,
    input logic dq_oe_r,
    input logic echo_clock_true_r,
    input logic echo_clock_comp_r,
    input logic output_valid_flag_r,
    input logic [`DDRS_IW-1:0] drive_imp_code_r,
    input logic term_enable_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [10:0] since_rst_r;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            since_rst_r <= 11'h000;
        else if (since_rst_r != 11'h7ff)
            since_rst_r <= since_rst_r + 11'h001;
    end
    // half a link cycle is about eight system clocks
    sequence s_qv_pulse;
        output_valid_flag_r[*6] ##[1:4] !output_valid_flag_r;
    endsequence
    sequence s_two_words;
        dq_oe_r[*8] ##1 dq_oe_r[*6] ##[1:4] !dq_oe_r;
    endsequence
    property p_qv_half;
        $rose(output_valid_flag_r) |-> s_qv_pulse;
    endproperty
    a_qv_half: assert property (p_qv_half) else $error("valid flag pulse not half a cycle");
    property p_oe_qv;
        $rose(dq_oe_r) |-> $fell(output_valid_flag_r);
    endproperty
    a_oe_qv: assert property (p_oe_qv) else $error("first word not where valid flag falls");
    property p_burst_two;
        $rose(dq_oe_r) |-> s_two_words;
    endproperty
    a_burst_two: assert property (p_burst_two) else $error("drive window not two words");
    property p_word_hold;
        $rose(dq_oe_r) |=> $stable(dq_out_r)[*6];
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("first word not held");
    property p_data_on_echo;
        $changed(dq_out_r) && dq_oe_r |-> $changed(echo_clock_true_r);
    endproperty
    a_data_on_echo: assert property (p_data_on_echo) else $error("data moved off an echo edge");
    property p_echo_comp;
        echo_clock_comp_r != echo_clock_true_r;
    endproperty
    a_echo_comp: assert property (p_echo_comp) else $error("echo clocks not complementary");
    property p_term_off;
        $past(dq_oe_r) && dq_oe_r |-> !term_enable_r;
    endproperty
    a_term_off: assert property (p_term_off) else $error("termination on while driving");
    property p_imp_mid;
        since_rst_r == 11'h000 |-> drive_imp_code_r == `DDRS_IMP_MID;
    endproperty
    a_imp_mid: assert property (p_imp_mid) else $error("impedance not mid after reset");
endmodule
bind ddrs_sram ddrs_monitor u_ddrs_monitor (
    .clock(clock),
    .nrst(nrst),
    .dq_out_r(dq_out_r),
    .dq_oe_r(dq_oe_r),
    .echo_clock_true_r(echo_clock_true_r),
    .echo_clock_comp_r(echo_clock_comp_r),
    .output_valid_flag_r(output_valid_flag_r),
    .drive_imp_code_r(drive_imp_code_r),
    .term_enable_r(term_enable_r)
);

// ==== verification/ddrs_ctrl_model.sv ====
// memory controller model: makes the link clocks, issues commands and write beats
// assumes the core samples every pin on its own clock
`timescale 1ns/1ps
`include "ddrs_consts.vh"
module ddrs_ctrl_model (
    input logic clock,
    output logic k_clk,
    output logic k_clk_n,
    output logic load_address_n,
    output logic read_not_write,
    output logic [`DDRS_AW-1:0] sync_address_in,
    output logic [`DDRS_DW-1:0] dq_in,
    output logic [`DDRS_NB-1:0] byte_write_mask_n
);
    assign k_clk_n = ~k_clk;
    initial
    begin
        k_clk = 1'b0;
        load_address_n = 1'b1;
        read_not_write = 1'b1;
        sync_address_in = '0;
        dq_in = '0;
        byte_write_mask_n = '1;
        #3.3;
        forever #80 k_clk = ~k_clk;
    end
    // quarter cycle ahead of the next k (rise=1) or k-bar rise, then on clock
    task automatic quarter(input logic rise);
        if (rise)
            @(negedge k_clk);
        else
            @(posedge k_clk);
        #40;
        @(posedge clock);
    endtask
    task automatic cmd(input logic ld_n, input logic rnw, input logic [`DDRS_AW-1:0] a,
                       input logic [`DDRS_DW-1:0] d0, input logic [`DDRS_DW-1:0] d1,
                       input logic [1:0] m0, input logic [1:0] m1);
        quarter(1'b1);
        load_address_n <= ld_n;
        read_not_write <= rnw;
        sync_address_in <= a;
        quarter(1'b0);
        load_address_n <= 1'b1;
        read_not_write <= ~rnw;
        sync_address_in <= ~a;
        if (!ld_n && !rnw)
        begin
            quarter(1'b1);
            dq_in <= d0;
            byte_write_mask_n <= m0;
            quarter(1'b0);
            dq_in <= d1;
            byte_write_mask_n <= m1;
        end
        // released bus shows the inverse; next command lands two k edges on
        quarter(1'b1);
        dq_in <= ~dq_in;
        byte_write_mask_n <= ~byte_write_mask_n;
    endtask
endmodule

// ==== verification/ddrs_sram_bench.sv ====
// self-checking bench for ddrs_sram with a controller model on the link side
// assumes the model drives all link pins; the bench owns reset and static pins
`timescale 1ns/1ps
`include "ddrs_consts.vh"
module ddrs_sram_bench;
    logic clock, nrst, dll_bypass_n, termination_control, at_supply, cmp_high;
    logic k_clk, k_clk_n, load_n, rnw, dq_oe_r, echo_t, echo_c, qv, term_enable_r;
    logic [`DDRS_AW-1:0] addr;
    logic [`DDRS_DW-1:0] dq_in, dq_out_r;
    logic [`DDRS_NB-1:0] mask_n;
    logic [`DDRS_IW-1:0] drive_imp_code_r, term_imp_code_r, saved;
    logic [`DDRS_DW-1:0] shadow [logic [`DDRS_MAW-1:0]];
    logic [`DDRS_DW-1:0] got_q [$];
    logic [`DDRS_AW-1:0] pool [6];
    logic [31:0] r0, r1;
    logic qv_q, echo_q, want;
    int errors, checks_done;
    ddrs_ctrl_model u_ddrs_ctrl_model (.clock(clock), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .load_address_n(load_n), .read_not_write(rnw), .sync_address_in(addr), .dq_in(dq_in),
        .byte_write_mask_n(mask_n));
    ddrs_sram u_ddrs_sram (.clock(clock), .nrst(nrst), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .load_address_n(load_n), .read_not_write(rnw), .sync_address_in(addr), .dq_in(dq_in),
        .byte_write_mask_n(mask_n), .dll_bypass_n(dll_bypass_n), .termination_control(termination_control),
        .impedance_ref_pin_at_supply(at_supply), .impedance_ref_pin_cmp_high(cmp_high),
        .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r), .echo_clock_true_r(echo_t), .echo_clock_comp_r(echo_c),
        .output_valid_flag_r(qv), .drive_imp_code_r(drive_imp_code_r),
        .term_imp_code_r(term_imp_code_r), .term_enable_r(term_enable_r));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // read words: first where the valid flag falls, second on the next echo edge
    always @(negedge clock)
    begin
        if (qv_q && !qv)
        begin
            got_q.push_back(dq_out_r);
            want = 1'b1;
        end
        else if (want && echo_q != echo_t)
        begin
            got_q.push_back(dq_out_r);
            want = 1'b0;
        end
        qv_q = qv;
        echo_q = echo_t;
    end
    task automatic check(input logic [`DDRS_DW-1:0] seen, input logic [`DDRS_DW-1:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [`DDRS_DW-1:0] merge(logic [`DDRS_DW-1:0] old, logic [`DDRS_DW-1:0] d,
                                                   logic [1:0] m);
        merge = old;
        if (!m[0])
            merge[8:0] = d[8:0];
        if (!m[1])
            merge[17:9] = d[17:9];
    endfunction
    task automatic do_write(input logic [`DDRS_AW-1:0] a, input logic [31:0] r, input logic [31:0] s);
        u_ddrs_ctrl_model.cmd(1'b0, 1'b0, a, r[17:0], s[17:0], r[31:30], s[31:30]);
        shadow[{a, 1'b0}] = merge(shadow[{a, 1'b0}], r[17:0], r[31:30]);
        shadow[{a, 1'b1}] = merge(shadow[{a, 1'b1}], s[17:0], s[31:30]);
    endtask
    task automatic do_read(input logic [`DDRS_AW-1:0] a);
        int n;
        got_q.delete();
        u_ddrs_ctrl_model.cmd(1'b0, 1'b1, a, '0, '0, 2'b00, 2'b00);
        n = 0;
        while (got_q.size() < 2 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        for (int i = 0; i < 2; i++)
            check(got_q.size() ? got_q.pop_front() : 'x, shadow[{a, i[0]}]);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (80000) @(posedge clock);
        errors++;
        report_and_stop();
    end
    initial
    begin
        errors = 0;
        checks_done = 0;
        nrst = 1'b0;
        dll_bypass_n = 1'b1;
        termination_control = 1'b1;
        at_supply = 1'b0;
        cmp_high = 1'b1;
        qv_q = 1'b0;
        echo_q = 1'b0;
        want = 1'b0;
        void'($urandom(32'hfb93));
        repeat (20) @(posedge clock);
        check(drive_imp_code_r, `DDRS_IMP_MID);
        nrst <= 1'b1;
        // comparator reports too high throughout, so calibration ends at the top code
        repeat (1030) @(posedge clock);
        check(drive_imp_code_r, `DDRS_IMP_MAX);
        $display("impedance start test done");
        pool[0] = 20'h00000;
        pool[1] = 20'hfffff;
        for (int i = 0; i < 6; i++)
        begin
            r0 = $urandom;
            if (i > 1)
                pool[i] = r0[19:0];
            do_write(pool[i], {2'b00, r0[29:0]}, {2'b00, $urandom} & 32'h3fffffff);
        end
        // partial masks, then read back from the write buffer
        do_write(pool[0], 32'h8001_2345, 32'h4000_abcd);
        do_read(pool[0]);
        $display("buffered write test done");
        repeat (60)
        begin
            r0 = $urandom;
            r1 = $urandom;
            case (r1[9:8])
                2'd0: do_write(pool[r1[2:0] % 6], r0, r1);
                2'd1: u_ddrs_ctrl_model.cmd(1'b1, r1[4], pool[0], '0, '0, 2'b00, 2'b00);
                default: do_read(pool[r1[2:0] % 6]);
            endcase
        end
        $display("random traffic test done");
        check(drive_imp_code_r > `DDRS_IMP_MID, 1'b1);
        saved = drive_imp_code_r;
        cmp_high <= 1'b0;
        repeat (2100) @(posedge clock);
        check(drive_imp_code_r < saved, 1'b1);
        at_supply <= 1'b1;
        repeat (1100) @(posedge clock);
        check(drive_imp_code_r, `DDRS_IMP_MAX);
        $display("impedance test done");
        repeat (8) @(posedge clock);
        check(term_imp_code_r, `DDRS_IMP_MAX);
        termination_control <= 1'b0;
        repeat (8) @(posedge clock);
        check(term_imp_code_r, `DDRS_IMP_MAX >> 1);
        check(term_enable_r, 1'b1);
        $display("termination test done");
        dll_bypass_n <= 1'b0;
        repeat (8) @(posedge clock);
        do_read(pool[1]);
        $display("dll off test done");
        report_and_stop();
    end
endmodule
